// >>> dmfm_defines.vh
// constants for the drive minor fault monitor
`ifndef DMFM_DEFINES_VH
`define DMFM_DEFINES_VH
`define DMFM_CLK_HZ            40000000
`define DMFM_CONFLICT_TIME_MS  500
`define DMFM_CONFLICT_CYCLES   ((`DMFM_CLK_HZ / 1000) * `DMFM_CONFLICT_TIME_MS)
`define DMFM_CYCLES_PER_MS     (`DMFM_CLK_HZ / 1000)
`define DMFM_FUNC_DRIVE_ENABLE 8'h6A
`define DMFM_ADDR_CTRL         12'h000
`define DMFM_ADDR_LIMIT        12'h004
`define DMFM_ADDR_TIME         12'h008
`define DMFM_ADDR_FUNC         12'h00C
`define DMFM_ADDR_STATUS       12'h010
`define DMFM_CTRL_ENC_BIT      0
`define DMFM_RST_LIMIT         16'h0064
`define DMFM_RST_TIME_MS       16'h0064
`define DMFM_ST_SPEED          0
`define DMFM_ST_DIODE          1
`define DMFM_ST_DISABLED       2
`define DMFM_ST_CONFLICT       3
`define DMFM_ST_PANEL          4
`define DMFM_ST_RAMP           5
`endif

// >>> dmfm_qual_timer.v
// qualification timer: output rises once condition held longer than limit
`timescale 1ns/1ps
module dmfm_qual_timer #(
  parameter W = 32
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         cond,
  input  wire [W-1:0] limit,
  output wire         expired
);
  reg [W-1:0] cnt_q;
  reg         exp_q;

  // counter restarts whenever the condition drops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      exp_q <= 1'b0;
    end else if (!cond) begin
      cnt_q <= {W{1'b0}};
      exp_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      exp_q <= 1'b1;        // strictly longer than limit
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign expired = exp_q;
endmodule

// >>> dmfm_top.v
// drive minor fault monitor with apb register access
`timescale 1ns/1ps
`include "dmfm_defines.vh"
// Notes on behaviour
// - speed error alarm when speed gap exceeds limit longer than error time
// - speed error alarm evaluated only with encoder card feedback
// - diode fan alarm follows any diode module fan alarm
// - input assigned function 6A turning off raises drive disabled alarm
// - conflict alarm when forward and reverse both on beyond 0.5 s
// - conflict alarm commands a ramp stop, not a coast
// - panel fan alarm follows panel fan controller alarm
module dmfm_top #(
  parameter NDIODE    = 4,
  parameter NIN       = 8,
  parameter SW        = 16,
  parameter CONF_CYC  = `DMFM_CONFLICT_CYCLES
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire [SW-1:0]     speed_ref,
  input  wire [SW-1:0]     speed_fb,
  input  wire              encoder_present,
  input  wire [NDIODE-1:0] diode_fan_fault,
  input  wire              panel_fan_fault,
  input  wire [NIN-1:0]    contact_in,
  input  wire              fwd_run,
  input  wire              rev_run,
  output reg               speed_error_alarm,
  output reg               diode_fan_alarm,
  output reg               drive_disabled_alarm,
  output reg               run_direction_conflict_alarm,
  output reg               panel_fan_alarm,
  output reg               ramp_stop
);
  reg  [31:0]      ctrl_q;
  reg  [SW-1:0]    speed_error_limit_q;
  reg  [15:0]      speed_error_time_q;
  reg  [8*NIN-1:0] contact_input_function_select_q;
  reg  [SW-1:0]    gap;
  reg              en_any;
  reg              en_all_on;
  wire             spd_exp;
  wire             conf_exp;
  wire [31:0]      spd_limit;
  wire             wr_en;
  wire             addr_ok;
  wire             spd_cond;
  wire             conf_cond;
  integer          i;

  // absolute difference of two speeds
  function [SW-1:0] absdiff;
    input [SW-1:0] a;
    input [SW-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // register map, one aligned word each:
  //   ctrl   bit0 enables the speed check
  //   limit  speed gap allowed before timing starts
  //   time   error time in ms, scaled below
  //   func   write-only: byte0 input index, byte1 function code
  //   status live alarm levels, read-only
  // the function table is write-only to keep the read mux small;
  // software must keep its own copy of what it assigned

  // apb: zero wait states, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `DMFM_ADDR_CTRL) || (paddr == `DMFM_ADDR_LIMIT) ||
                   (paddr == `DMFM_ADDR_TIME) || (paddr == `DMFM_ADDR_FUNC) ||
                   (paddr == `DMFM_ADDR_STATUS);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok;

  // register writes; function table written one input per word at func offset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q                          <= 32'h0000_0000;
      speed_error_limit_q             <= `DMFM_RST_LIMIT;
      speed_error_time_q              <= `DMFM_RST_TIME_MS;
      contact_input_function_select_q <= {(8*NIN){1'b0}};
    end else if (wr_en) begin
      case (paddr)
        `DMFM_ADDR_CTRL:  ctrl_q <= pwdata;
        `DMFM_ADDR_LIMIT: speed_error_limit_q <= pwdata[SW-1:0];
        `DMFM_ADDR_TIME:  speed_error_time_q <= pwdata[15:0];
        `DMFM_ADDR_FUNC: begin
          // low byte picks the input, next byte its function code
          for (i = 0; i < NIN; i = i + 1) begin
            if (pwdata[7:0] == i[7:0])
              contact_input_function_select_q[8*i +: 8] <= pwdata[15:8];
          end
        end
        default: ;
      endcase
    end
  end

  // read mux; status shows live alarms
  always @* begin
    prdata = 32'h0000_0000;
    case (paddr)
      `DMFM_ADDR_CTRL:  prdata = ctrl_q;
      `DMFM_ADDR_LIMIT: prdata[SW-1:0] = speed_error_limit_q;
      `DMFM_ADDR_TIME:  prdata[15:0] = speed_error_time_q;
      `DMFM_ADDR_STATUS: begin
        prdata[`DMFM_ST_SPEED]    = speed_error_alarm;
        prdata[`DMFM_ST_DIODE]    = diode_fan_alarm;
        prdata[`DMFM_ST_DISABLED] = drive_disabled_alarm;
        prdata[`DMFM_ST_CONFLICT] = run_direction_conflict_alarm;
        prdata[`DMFM_ST_PANEL]    = panel_fan_alarm;
        prdata[`DMFM_ST_RAMP]     = ramp_stop;
      end
      default: prdata = 32'h0000_0000;
    endcase
  end

  // speed gap and drive-enable input scan
  always @* begin
    gap       = absdiff(speed_ref, speed_fb);
    en_any    = 1'b0;
    en_all_on = 1'b1;
    for (i = 0; i < NIN; i = i + 1) begin
      if (contact_input_function_select_q[8*i +: 8] == `DMFM_FUNC_DRIVE_ENABLE) begin
        en_any = 1'b1;
        if (!contact_in[i])
          en_all_on = 1'b0;
      end
    end
  end

  // error time in ms scaled to clock cycles
  assign spd_limit = speed_error_time_q * `DMFM_CYCLES_PER_MS;

  // speed check needs both the card present and software enable;
  // either one dropping restarts the timer, so no stale count survives
  assign spd_cond = (gap > speed_error_limit_q) & encoder_present &
                    ctrl_q[`DMFM_CTRL_ENC_BIT];

  // both run contacts closed at once
  assign conf_cond = fwd_run & rev_run;

  // speed deviation qualification, only with encoder feedback
  dmfm_qual_timer #(.W(32)) u_spd (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (spd_cond),
    .limit   (spd_limit),
    .expired (spd_exp)
  );

  // forward and reverse both closed
  dmfm_qual_timer #(.W(32)) u_conf (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (conf_cond),
    .limit   (CONF_CYC),
    .expired (conf_exp)
  );

  // speed error alarm; clears with the timer when the gap closes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_error_alarm <= 1'b0;
    end else begin
      speed_error_alarm <= spd_exp;
    end
  end

  // diode fan alarm; any single module fault is enough
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diode_fan_alarm <= 1'b0;
    end else begin
      diode_fan_alarm <= |diode_fan_fault;
    end
  end

  // drive disabled; a level, so it clears once the input closes again
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_disabled_alarm <= 1'b0;
    end else begin
      drive_disabled_alarm <= en_any & ~en_all_on;
    end
  end

  // run direction conflict alarm
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_direction_conflict_alarm <= 1'b0;
    end else begin
      run_direction_conflict_alarm <= conf_exp;
    end
  end

  // ramp stop request; same timing as the alarm so the two never disagree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ramp_stop <= 1'b0;
    end else begin
      ramp_stop <= conf_exp;
    end
  end

  // panel fan alarm follows the fan controller
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_fan_alarm <= 1'b0;
    end else begin
      panel_fan_alarm <= panel_fan_fault;
    end
  end
endmodule

// >>> dmfm_far.sv
// far-side model: terminal contacts and run commands
`timescale 1ns/1ps
module dmfm_far (
  input  wire       pclk,
  input  wire [9:0] cmd,
  output reg  [9:0] pins = 10'h000
);
  // contacts settle one clock after the bench asks, never mid-cycle
  always @(posedge pclk)
    pins <= cmd;
endmodule

// >>> dmfm_top_assertions.sv
// port assertions for the minor fault monitor
`timescale 1ns/1ps
module dmfm_top_assertions #(
  parameter CONF_CYC = 50
) (
  input wire       pclk,
  input wire       presetn,
  input wire       encoder_present,
  input wire [3:0] diode_fan_fault,
  input wire       panel_fan_fault,
  input wire [7:0] contact_in,
  input wire       fwd_run,
  input wire       rev_run,
  input wire       speed_error_alarm,
  input wire       diode_fan_alarm,
  input wire       drive_disabled_alarm,
  input wire       run_direction_conflict_alarm,
  input wire       panel_fan_alarm,
  input wire       ramp_stop
);
  int cnt_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // edges with both run contacts closed; a counter, as the limit is long
  always @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= 0;
    else cnt_q <= (fwd_run && rev_run) ? cnt_q + 1 : 0;
  property p_df; 1 |=> diode_fan_alarm == |$past(diode_fan_fault); endproperty
  a_df: assert property (p_df) else $error("diode alarm wrong");
  property p_pf; 1 |=> panel_fan_alarm == $past(panel_fan_fault); endproperty
  a_pf: assert property (p_pf) else $error("panel alarm wrong");
  property p_rs; ramp_stop == run_direction_conflict_alarm; endproperty
  a_rs: assert property (p_rs) else $error("ramp stop wrong");
  property p_ce; $rose(run_direction_conflict_alarm) |-> cnt_q >= CONF_CYC; endproperty
  a_ce: assert property (p_ce) else $error("conflict early");
  property p_cl; cnt_q == CONF_CYC + 4 |-> run_direction_conflict_alarm; endproperty
  a_cl: assert property (p_cl) else $error("conflict late");
  property p_cc; !(fwd_run && rev_run) |=> ##1 !run_direction_conflict_alarm; endproperty
  a_cc: assert property (p_cc) else $error("conflict stuck");
  property p_se; !encoder_present |=> ##1 !speed_error_alarm; endproperty
  a_se: assert property (p_se) else $error("speed without encoder");
  property p_dd; &contact_in |=> !drive_disabled_alarm; endproperty
  a_dd: assert property (p_dd) else $error("disabled while closed");
endmodule
bind dmfm_top dmfm_top_assertions #(.CONF_CYC(CONF_CYC)) u_chk (.*);

// >>> tb.sv
// self-checking bench for the minor fault monitor
`timescale 1ns/1ps
`include "dmfm_defines.vh"
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic encoder_present = 0, panel_fan_fault = 0, fwd_run, rev_run, speed_error_alarm;
  logic diode_fan_alarm, drive_disabled_alarm, run_direction_conflict_alarm;
  logic panel_fan_alarm, ramp_stop;
  logic [3:0] diode_fan_fault = 0;
  logic [7:0] contact_in;
  logic [9:0] cmd = 0;
  logic [11:0] paddr = 0;
  logic [15:0] speed_ref = 0, speed_fb = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [32:0] q[$];
  int mismatches = 0, checks = 0, seed = 26390;
  always #12.5 pclk = ~pclk;
  dmfm_top #(.CONF_CYC(50)) u_dut (.*);
  dmfm_far u_far (.pclk(pclk), .cmd(cmd), .pins({rev_run, fwd_run, contact_in}));
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value read_data exp %h seen %h", exp, seen);
    end
  endtask
  task results;
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // apb transfer; a read notes {pslverr, prdata} as its expected answer
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d[31:0]};
    if (!w) q.push_back(d);
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 16);
    {psel, penable} <= 2'b00;
    if (!pready) begin mismatches++; results; end
  endtask
  task st(input logic [5:0] e);
    apb(0, `DMFM_ADDR_STATUS, {27'h0, e});
  endtask
  // read monitor: oldest note against the returned word
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
  // main sequence; status bits speed,diode,disabled,conflict,panel,ramp
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `DMFM_ADDR_CTRL, 33'h0);
    apb(0, `DMFM_ADDR_LIMIT, 33'h64);
    apb(0, `DMFM_ADDR_TIME, 33'h64);
    apb(0, 12'h014, 33'h1_0000_0000);
    r = $random(seed);
    diode_fan_fault <= r[3:0] | 4'h1;
    panel_fan_fault <= 1;
    st(6'h12);
    diode_fan_fault <= 0;
    panel_fan_fault <= 0;
    st(6'h00);
    cmd <= 10'h3ff;
    apb(1, `DMFM_ADDR_FUNC, {17'h0_0000, `DMFM_FUNC_DRIVE_ENABLE, 8'h02});
    repeat (26) @(posedge pclk);
    cmd <= 10'h0ff; // short drop must restart the count
    @(posedge pclk);
    cmd <= 10'h3ff;
    repeat (40) @(posedge pclk);
    st(6'h00);
    repeat (15) @(posedge pclk);
    st(6'h28);
    cmd <= 10'h0fb;
    repeat (3) @(posedge pclk);
    st(6'h04);
    apb(1, `DMFM_ADDR_TIME, 33'h1);
    apb(1, `DMFM_ADDR_CTRL, 33'h1);
    r = $random(seed);
    speed_fb <= {1'b0, r[14:0]};
    speed_ref <= {1'b0, r[14:0]} + {8'h00, r[22:15]} + 16'h00c8;
    repeat (40100) @(posedge pclk);
    st(6'h04);
    encoder_present <= 1;
    repeat (39900) @(posedge pclk);
    st(6'h04);
    repeat (200) @(posedge pclk);
    st(6'h05);
    speed_fb <= speed_ref;
    repeat (3) @(posedge pclk);
    st(6'h04);
    results;
  end
endmodule
